// [rxeb_pkg.sv]
// Constants, types and register map of the receive alignment and elastic buffer block.
// Assumes a 32-bit plain register port and byte offsets on word boundaries.
package rxeb_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] RXEB_CTRL_OFS = 8'h00;
  localparam logic [7:0] RXEB_PAT_OFS = 8'h04;
  localparam logic [7:0] RXEB_CCS_OFS = 8'h08;
  localparam logic [7:0] RXEB_BOND_OFS = 8'h0C;
  localparam logic [7:0] RXEB_STAT_OFS = 8'h10;
  localparam logic [7:0] RXEB_MASK_OFS = 8'h14;
  localparam logic [7:0] RXEB_INFO_OFS = 8'h18;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int RXEB_CTRL_W = 13;
  localparam int RXEB_PAT_B_POS = 16;
  localparam int RXEB_INFO_PH_POS = 16;
  localparam int RXEB_EVT_W = 6;

  // ****************************************
  // Fixed characters and reset values
  // ****************************************
  localparam logic [9:0] RXEB_COMMA_PLUS = 10'h0FA;
  localparam logic [9:0] RXEB_COMMA_MINUS = 10'h305;
  localparam logic [12:0] RXEB_CTRL_RST = 13'h040D;
  localparam logic [9:0] RXEB_PAT_RST = 10'h0FA;
  localparam logic [9:0] RXEB_CC0_RST = 10'h0FA;
  localparam logic [9:0] RXEB_CC1_RST = 10'h305;
  localparam logic [5:0] RXEB_MASK_RST = 6'h00;
  localparam logic [3:0] RXEB_LAST_BIT = 4'h9;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    RXEB_AL_PLUS,
    RXEB_AL_MINUS,
    RXEB_AL_BOTH,
    RXEB_AL_CUSTOM
  } rxeb_align_t;

  typedef struct packed {
    logic [3:0] thresh;
    logic [3:0] spacing;
    logic cc_len2;
    logic cc_en;
    rxeb_align_t align_mode;
    logic comma_en;
  } rxeb_ctrl_t;

  typedef struct packed {
    logic ovf;
    logic unf;
    logic skip;
    logic rep;
    logic realign;
    logic comma;
  } rxeb_evt_t;

endpackage : rxeb_pkg

// [rxeb_top.sv]
// Receive word alignment, elastic buffer and clock correction.
// Assumes link clock, serial data and fabric read clock come from outside i_mclk.
// Operation
// R01: With detection on, two programmed 10-bit characters count as alignment marks.
// R02: A found mark pulses the comma output and aligns words to it.
// R03: A mark on the current boundary leaves the alignment as it is.
// R04: A mark off the boundary moves it and pulses a separate realign output.
// R05: Every incoming bit position is checked against the marks, always; the code checks only while comma_en is set.
// R06: With detection off, words are cut at a free-running arbitrary boundary.
// R07: Mark choice: plus comma, minus comma, both, or custom pair.
// R08: Write pointer moves on link clock, read pointer on fabric clock.
// R09: Buffer fill is steered around half full.
// R10: Writes and reads go on for every character, idle or not.
// R11: Only the configured removable sequence is used for corrections.
// R12: On low fill the read pointer steps back to reread one sequence.
// R13: Two-character sequence with spacing zero may repeat until refilled.
// R14: On high fill the read pointer jumps over one removable sequence.
// R15: With spacing zero two sequences may be skipped in one step.
// R16: The far transmitter inserts removable sequences often enough.
// R17: Software can shift the read pointer to align bonded lanes.
// R18: Bonded words are split bytewise, one lane per byte; the code has no byte split and outputs whole 10-bit words on o_rx_data.
// R19: Corrections only past the set distance from half and at sequence start.
`timescale 1ns/1ps

module rxeb_top #(
  parameter int DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_recovered_link_clock,
  input wire logic i_rx_sdata,
  input wire logic i_fabric_read_clock,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic [9:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_comma_det,
  output logic o_realign
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW+1:0] HALF = (PW+2)'(DEPTH / 2);
  localparam logic [PW+1:0] FULL = (PW+2)'(DEPTH);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] in_w, s1_r, s2_r, s3_r;
  logic [2:0] lvl_r, lvl_nxt, agree, rise;
  logic lk_edge, rd_edge, bit_in;

  assign in_w = {i_fabric_read_clock, i_rx_sdata, i_recovered_link_clock};

  // Level only changes once stages two and three agree
  always_comb begin
    agree = ~(s2_r ^ s3_r);
    lvl_nxt = (agree & s3_r) | (~agree & lvl_r);
    rise = agree & s3_r & ~lvl_r;
    lk_edge = rise[0];
    rd_edge = rise[2];
    bit_in = lvl_nxt[1];
  end

  // Stage one feeds stage two only
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
      lvl_r <= 3'h0;
    end else begin
      s1_r <= in_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  rxeb_pkg::rxeb_ctrl_t ctrl_r, ctrl_nxt;
  logic [9:0] pa_r, pb_r, pa_nxt, pb_nxt;
  logic [9:0] cc0_r, cc1_r, cc0_nxt, cc1_nxt;
  logic [5:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [31:0] rdata_nxt;
  logic irq_nxt, bond_wr;
  logic ev_ovf, ev_unf, ev_skip, ev_rep;
  rxeb_pkg::rxeb_evt_t evt;

  // ****************************************
  // Word alignment
  // ****************************************
  logic [9:0] sh_r, sh_nxt;
  logic [3:0] bcnt_r, bcnt_nxt, ph_r, ph_nxt, aph_r, aph_nxt;
  logic cdet_nxt, rlg_nxt, wr_go;

  // Mark selection by mode
  function automatic logic is_mark(input logic [9:0] w);
    logic m;
    m = 1'b0;
    unique case (ctrl_r.align_mode)
      rxeb_pkg::RXEB_AL_PLUS: m = (w == rxeb_pkg::RXEB_COMMA_PLUS); // R07
      rxeb_pkg::RXEB_AL_MINUS: m = (w == rxeb_pkg::RXEB_COMMA_MINUS); // R07
      rxeb_pkg::RXEB_AL_BOTH: m = (w == rxeb_pkg::RXEB_COMMA_PLUS) ||
                                  (w == rxeb_pkg::RXEB_COMMA_MINUS); // R07
      rxeb_pkg::RXEB_AL_CUSTOM: m = (w == pa_r) || (w == pb_r); // R01
    endcase
    return m;
  endfunction : is_mark

  // Bit-by-bit search; a word ends every tenth bit or on a mark
  always_comb begin
    sh_nxt = sh_r;
    bcnt_nxt = bcnt_r;
    ph_nxt = ph_r;
    aph_nxt = aph_r;
    cdet_nxt = 1'b0;
    rlg_nxt = 1'b0;
    wr_go = 1'b0;
    if (lk_edge) begin
      sh_nxt = {sh_r[8:0], bit_in};
      ph_nxt = (ph_r == rxeb_pkg::RXEB_LAST_BIT) ? 4'h0 : ph_r + 4'h1;
      if (ctrl_r.comma_en && is_mark(sh_nxt)) begin // R05 R01
        cdet_nxt = 1'b1; // R02
        wr_go = 1'b1; // R02
        bcnt_nxt = 4'h0;
        if (bcnt_r != rxeb_pkg::RXEB_LAST_BIT) begin // R03
          rlg_nxt = 1'b1; // R04
          aph_nxt = ph_r; // R04
        end
      end else if (bcnt_r == rxeb_pkg::RXEB_LAST_BIT) begin // R06
        wr_go = 1'b1;
        bcnt_nxt = 4'h0;
      end else begin
        bcnt_nxt = bcnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      sh_r <= 10'h000;
      bcnt_r <= 4'h0;
      ph_r <= 4'h0;
      aph_r <= 4'h0;
      o_comma_det <= 1'b0;
      o_realign <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      bcnt_r <= bcnt_nxt;
      ph_r <= ph_nxt;
      aph_r <= aph_nxt;
      o_comma_det <= cdet_nxt;
      o_realign <= rlg_nxt;
    end
  end

  // ****************************************
  // Elastic buffer
  // ****************************************
  logic [9:0] mem [DEPTH];
  logic [PW:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt, sst_r, sst_nxt;
  logic [PW:0] idx, skp, lenw;
  logic [PW+1:0] fill, thr;
  logic pos_r, pos_nxt, bpend_r, bpend_nxt;
  logic [3:0] gap_r, gap_nxt, boff_r, boff_nxt;
  logic [9:0] odat_nxt;
  logic oval_nxt, mem_we, low, high, high2, send;

  // Sequence start at p, fully written
  function automatic logic at_seq(input logic [PW:0] p);
    logic [PW:0] q;
    logic [PW:0] av;
    logic ok;
    q = p + (PW+1)'(1);
    av = wptr_r - p;
    ok = ctrl_r.cc_len2 ? (av > (PW+1)'(1)) : (av != '0);
    return ctrl_r.cc_en && ok && (mem[p[PW-1:0]] == cc0_r) &&
           (!ctrl_r.cc_len2 || (mem[q[PW-1:0]] == cc1_r)); // R11
  endfunction : at_seq

  // Fill level against the correction window
  always_comb begin
    fill = {1'b0, wptr_r - rptr_r};
    thr = (PW+2)'(ctrl_r.thresh);
    lenw = ctrl_r.cc_len2 ? (PW+1)'(2) : (PW+1)'(1);
    low = (fill + thr) < HALF; // R09 R19
    high = fill > (HALF + thr); // R09 R19
    high2 = fill > (HALF + thr + {1'b0, lenw});
  end

  // Write side; every character goes in, idle or data, except when the buffer is full
  always_comb begin
    wptr_nxt = wptr_r;
    mem_we = 1'b0;
    ev_ovf = 1'b0;
    if (wr_go) begin // R10
      if (fill == FULL) begin
        ev_ovf = 1'b1; // Drop rather than corrupt unread data
      end else begin
        mem_we = 1'b1;
        wptr_nxt = wptr_r + (PW+1)'(1); // R08
      end
    end
  end

  // Read side with repeat, skip and bonding shift
  always_comb begin
    rptr_nxt = rptr_r;
    sst_nxt = sst_r;
    pos_nxt = pos_r;
    gap_nxt = gap_r;
    odat_nxt = o_rx_data;
    oval_nxt = 1'b0;
    bpend_nxt = bpend_r | bond_wr;
    boff_nxt = bond_wr ? i_wdata[3:0] : boff_r;
    skp = '0;
    idx = rptr_r;
    send = 1'b0;
    ev_skip = 1'b0;
    ev_rep = 1'b0;
    ev_unf = 1'b0;
    if (rd_edge) begin
      if (bpend_r) begin
        rptr_nxt = rptr_r + {{(PW-3){boff_r[3]}}, boff_r}; // R17
        bpend_nxt = bond_wr;
        pos_nxt = 1'b0;
      end else if (fill == '0) begin
        ev_unf = 1'b1;
      end else begin
        if (!pos_r && gap_r == 4'h0 && high && at_seq(rptr_r)) begin // R19
          skp = lenw; // R14
          ev_skip = 1'b1;
          if (ctrl_r.spacing == 4'h0 && high2 && at_seq(rptr_r + lenw)) begin
            skp = lenw + lenw; // R15
          end
        end
        idx = rptr_r + skp;
        odat_nxt = mem[idx[PW-1:0]];
        oval_nxt = 1'b1; // R10
        rptr_nxt = idx + (PW+1)'(1); // R08
        if (pos_r) begin
          pos_nxt = 1'b0;
        end else if (ctrl_r.cc_len2 && at_seq(idx)) begin
          pos_nxt = 1'b1;
          sst_nxt = idx;
        end
        send = ctrl_r.cc_len2 ? pos_r : at_seq(idx);
        if (send && !ev_skip && gap_r == 4'h0 && low) begin // R19
          rptr_nxt = ctrl_r.cc_len2 ? sst_r : idx; // R12
          ev_rep = 1'b1;
        end
        // Spacing zero lets a long sequence repeat back to back
        if (ev_skip || ev_rep) begin
          if (ctrl_r.spacing != 4'h0) begin
            gap_nxt = ctrl_r.spacing;
          end else begin
            gap_nxt = ctrl_r.cc_len2 ? 4'h0 : 4'h1; // R13
          end
        end else if (gap_r != 4'h0) begin
          gap_nxt = gap_r - 4'h1;
        end
      end
    end
  end

  // Memory has no reset; pointers guard every read
  always_ff @(posedge i_mclk) begin
    if (mem_we) begin
      mem[wptr_r[PW-1:0]] <= sh_nxt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      sst_r <= '0;
      pos_r <= 1'b0;
      gap_r <= 4'h0;
      bpend_r <= 1'b0;
      boff_r <= 4'h0;
      o_rx_data <= 10'h000;
      o_rx_valid <= 1'b0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      sst_r <= sst_nxt;
      pos_r <= pos_nxt;
      gap_r <= gap_nxt;
      bpend_r <= bpend_nxt;
      boff_r <= boff_nxt;
      o_rx_data <= odat_nxt; // R18
      o_rx_valid <= oval_nxt;
    end
  end

  // ****************************************
  // Register port and interrupt
  // ****************************************
  assign evt = '{ovf: ev_ovf, unf: ev_unf, skip: ev_skip, rep: ev_rep, realign: rlg_nxt, comma: cdet_nxt};
  assign bond_wr = i_wr && (i_addr == rxeb_pkg::RXEB_BOND_OFS);

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    ctrl_nxt = ctrl_r;
    pa_nxt = pa_r;
    pb_nxt = pb_r;
    cc0_nxt = cc0_r;
    cc1_nxt = cc1_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    rdata_nxt = 32'h0000_0000;
    if (i_wr) begin
      unique case (i_addr)
        rxeb_pkg::RXEB_CTRL_OFS: ctrl_nxt = rxeb_pkg::rxeb_ctrl_t'(i_wdata[12:0]);
        rxeb_pkg::RXEB_PAT_OFS: begin
          pa_nxt = i_wdata[9:0];
          pb_nxt = i_wdata[rxeb_pkg::RXEB_PAT_B_POS +: 10];
        end
        rxeb_pkg::RXEB_CCS_OFS: begin
          cc0_nxt = i_wdata[9:0];
          cc1_nxt = i_wdata[rxeb_pkg::RXEB_PAT_B_POS +: 10];
        end
        rxeb_pkg::RXEB_STAT_OFS: stat_nxt = stat_r & ~i_wdata[5:0];
        rxeb_pkg::RXEB_MASK_OFS: mask_nxt = i_wdata[5:0];
        default: ;
      endcase
    end
    stat_nxt = stat_nxt | evt;
    irq_nxt = |(stat_nxt & mask_nxt);
    // Unmapped and write-only offsets read as zero
    if (i_rd) begin
      unique case (i_addr)
        rxeb_pkg::RXEB_CTRL_OFS: rdata_nxt = 32'(ctrl_r);
        rxeb_pkg::RXEB_PAT_OFS: rdata_nxt = {6'h00, pb_r, 6'h00, pa_r};
        rxeb_pkg::RXEB_CCS_OFS: rdata_nxt = {6'h00, cc1_r, 6'h00, cc0_r};
        rxeb_pkg::RXEB_STAT_OFS: rdata_nxt = 32'(stat_r);
        rxeb_pkg::RXEB_MASK_OFS: rdata_nxt = 32'(mask_r);
        rxeb_pkg::RXEB_INFO_OFS: rdata_nxt = 32'(fill) |
                                  (32'(aph_r) << rxeb_pkg::RXEB_INFO_PH_POS);
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      ctrl_r <= rxeb_pkg::rxeb_ctrl_t'(rxeb_pkg::RXEB_CTRL_RST);
      pa_r <= rxeb_pkg::RXEB_PAT_RST;
      pb_r <= rxeb_pkg::RXEB_PAT_RST;
      cc0_r <= rxeb_pkg::RXEB_CC0_RST;
      cc1_r <= rxeb_pkg::RXEB_CC1_RST;
      stat_r <= 6'h00;
      mask_r <= rxeb_pkg::RXEB_MASK_RST;
      o_rdata <= 32'h0000_0000;
      o_irq <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      pa_r <= pa_nxt;
      pb_r <= pb_nxt;
      cc0_r <= cc0_nxt;
      cc1_r <= cc1_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      o_rdata <= rdata_nxt;
      o_irq <= irq_nxt;
    end
  end

endmodule : rxeb_top

// [rxeb_top_asserts.sv]
// Checker of the receive alignment block, seen only through its top ports.
// Assumes one clock i_mclk and synchronous active-low reset i_nrst.
`timescale 1ns/1ps

module rxeb_top_asserts #(
  parameter int DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_recovered_link_clock,
  input wire logic i_rx_sdata,
  input wire logic i_fabric_read_clock,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_irq,
  input wire logic [9:0] o_rx_data,
  input wire logic o_rx_valid,
  input wire logic o_comma_det,
  input wire logic o_realign
);
  // ********
  // Port relations
  // ********
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  // Quiet outputs right after reset release
  AST_RESET_QUIET: assert property ($rose(i_nrst) |-> !o_rx_valid && !o_comma_det && !o_realign && o_rdata == 32'h0)
    else $error("output active at reset release");
  // Read data only in the cycle after a read strobe
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read cycle");
  AST_VALID_PULSE: assert property (o_rx_valid |=> !o_rx_valid)
    else $error("valid longer than one cycle");
  AST_DATA_HOLD: assert property (!o_rx_valid |-> $stable(o_rx_data))
    else $error("data changed without valid");
  // One link bit is 12 clocks, so marks cannot come closer
  AST_COMMA_PULSE: assert property (o_comma_det |=> !o_comma_det [*8])
    else $error("comma pulses too close");
  AST_REALIGN_TIED: assert property (o_realign |-> o_comma_det)
    else $error("realign without comma");
  AST_COMMA_ON_LINK: assert property (o_comma_det |-> $past(i_recovered_link_clock, 2))
    else $error("comma not after a link edge");
  // Status only clears through a register write
  AST_IRQ_FALL: assert property ($fell(o_irq) |-> i_wr || $past(i_wr) || $past(i_wr, 2))
    else $error("irq dropped without write");
endmodule : rxeb_top_asserts

bind rxeb_top rxeb_top_asserts #(.DEPTH(DEPTH)) i_rxeb_top_asserts (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_recovered_link_clock(i_recovered_link_clock),
  .i_rx_sdata(i_rx_sdata), .i_fabric_read_clock(i_fabric_read_clock), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
  .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .o_comma_det(o_comma_det), .o_realign(o_realign)
);

// [rxeb_link_model.sv]
// Behavioural far transmitter: serial bits beside a 48 ns link clock.
// Assumes the bench calls send from one process at a time.
`timescale 1ns/1ps

module rxeb_link_model (
  output logic o_lclk,
  output logic o_sdata
);
  // ********
  // Serial framing
  // ********
  initial begin
    o_lclk = 1'b0;
    o_sdata = 1'b0;
  end

  // Top n bits of c, first bit first; clock stands low between frames
  task automatic send(input logic [9:0] c, input int n);
    #1; // Keep pin edges off the system clock edges
    for (int i = 9; i > 9 - n; i--) begin
      o_sdata = c[i]; // Change while clock is low
      #24 o_lclk = 1'b1;
      #24 o_lclk = 1'b0;
    end
    o_sdata = ~o_sdata; // Released line must not show a stale bit
    #3; // Frame length stays a whole number of clock periods
  endtask : send
endmodule : rxeb_link_model

// [tb_top.sv]
// Self-checking bench of the receive alignment and elastic buffer block.
// Assumes package, design, checker and link model are compiled before it.
`timescale 1ns/1ps

module tb_top;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_fabric_read_clock = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [9:0] o_rx_data;
  logic o_irq, o_rx_valid, o_comma_det, o_realign, lclk, sdata;
  logic rd_on = 1'b0;
  real half = 200.0;
  logic [9:0] rxq[$];
  int ccnt, rcnt, error_cnt, total_checks, cyc;

  // ********
  // Clocks, instances, monitor
  // ********
  always #2 i_mclk = ~i_mclk;
  // Fabric read clock, unrelated to i_mclk
  always begin
    #(half);
    i_fabric_read_clock = rd_on ? ~i_fabric_read_clock : 1'b0;
  end

  rxeb_top #(.DEPTH(16)) i_rxeb_top (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_recovered_link_clock(lclk),
    .i_rx_sdata(sdata), .i_fabric_read_clock(i_fabric_read_clock), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_rx_data(o_rx_data),
    .o_rx_valid(o_rx_valid), .o_comma_det(o_comma_det), .o_realign(o_realign));
  rxeb_link_model i_rxeb_link_model (.o_lclk(lclk), .o_sdata(sdata));

  // Sample on the falling edge, away from output updates
  always @(negedge i_mclk) begin
    cyc++;
    if (o_rx_valid === 1'b1) rxq.push_back(o_rx_data);
    if (o_comma_det === 1'b1) ccnt++;
    if (o_realign === 1'b1) rcnt++;
    if (cyc == 60000) begin
      error_cnt++;
      test_done();
    end
  end

  // ********
  // Shared tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic do_reset();
    rd_on = 1'b0;
    wait (!i_fabric_read_clock); // No stale read edge across reset
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (8) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rxq.delete();
    ccnt = 0;
    rcnt = 0;
  endtask : do_reset

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // ********
  // Scenarios
  // ********
  // Reset values, unmapped write ignored, mask read back
  task automatic t_regs();
    logic [31:0] d;
    logic [7:0] ad[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
    logic [31:0] ev[7] = '{32'h040D, 32'h00FA00FA, 32'h030500FA, 32'h0, 32'h0, 32'h0, 32'h0};
    wr(8'h1C, 32'hFFFFFFFF);
    foreach (ad[i]) begin
      rd(ad[i], d);
      chk("register", ev[i], d);
    end
    wr(8'h14, 32'h3F);
    rd(8'h14, d);
    chk("mask", 32'h3F, d);
  endtask : t_regs

  // Off-boundary mark, repeat on boundary, second shift
  task automatic t_align();
    do_reset();
    i_rxeb_link_model.send(10'h2AA, 5);
    i_rxeb_link_model.send(10'h0FA, 10);
    chk("realign", 32'h1, rcnt);
    i_rxeb_link_model.send(10'h0FA, 10);
    chk("comma", 32'h2, ccnt);
    chk("realign", 32'h1, rcnt);
    i_rxeb_link_model.send(10'h2AA, 3);
    i_rxeb_link_model.send(10'h305, 10);
    chk("realign", 32'h2, rcnt);
  endtask : t_align

  // Each mark mode, then detection switched off
  task automatic t_modes();
    int ex[5] = '{1, 1, 2, 1, 0};
    logic [9:0] seq[7] = '{10'h2AA, 10'h0FA, 10'h2AA, 10'h305, 10'h2AA, 10'h1E3, 10'h2AA};
    for (int m = 0; m < 5; m++) begin
      do_reset();
      wr(8'h04, 32'h01E301E3);
      wr(8'h00, (m < 4) ? (32'h0401 | (32'(m) << 1)) : 32'h0404);
      foreach (seq[i]) i_rxeb_link_model.send(seq[i], 10);
      chk("mode commas", ex[m], ccnt);
    end
  endtask : t_modes

  // Idles between data; read rate off nominal forces corrections
  task automatic t_cc(input real h, input int sb);
    logic [31:0] d;
    int nd;
    do_reset();
    half = h;
    for (int i = 0; i < 60; i++) begin
      if (i == 10) rd_on = 1'b1;
      i_rxeb_link_model.send(i[0] ? (i[1] ? 10'h155 : 10'h2AA) : 10'h0FA, 10);
    end
    rd_on = 1'b0;
    repeat (40) @(posedge i_mclk);
    nd = 0;
    foreach (rxq[k]) begin
      if (rxq[k] !== 10'h0FA) begin
        chk("data order", nd[0] ? 32'h155 : 32'h2AA, rxq[k]);
        nd++;
      end
    end
    chk("data count", 32'h1, nd > 15);
    rd(8'h10, d);
    chk("correction flag", 32'h1, d[sb]);
  endtask : t_cc

  // Underflow event: masked, raised, cleared
  task automatic t_irq();
    logic [31:0] d;
    do_reset();
    half = 200.0;
    rd_on = 1'b1;
    repeat (300) @(posedge i_mclk);
    rd_on = 1'b0;
    rd(8'h10, d);
    chk("underflow flag", 32'h1, d[4]);
    chk("irq masked", 32'h0, o_irq);
    wr(8'h14, 32'h10);
    repeat (3) @(negedge i_mclk);
    chk("irq raised", 32'h1, o_irq);
    wr(8'h10, 32'h10);
    repeat (3) @(negedge i_mclk);
    chk("irq cleared", 32'h0, o_irq);
  endtask : t_irq

  // Full buffer drops a word; bond offset moves the read pointer
  task automatic t_bond();
    logic [31:0] d;
    do_reset();
    half = 200.0;
    for (int i = 0; i < 17; i++) begin
      i_rxeb_link_model.send((i == 2) ? 10'h333 : ((i == 3) ? 10'h0CC : 10'h2AA), 10);
    end
    rd(8'h10, d);
    chk("overflow flag", 32'h1, d[5]);
    wr(8'h0C, 32'h2);
    rd_on = 1'b1;
    repeat (250) @(posedge i_mclk);
    rd_on = 1'b0;
    repeat (10) @(posedge i_mclk);
    chk("bond word", 32'h333, rxq[0]);
    chk("bond next", 32'h0CC, rxq[1]);
  endtask : t_bond

  initial begin
    do_reset();
    t_regs();
    t_align();
    t_modes();
    t_cc(200.0, 2);
    t_cc(280.0, 3);
    t_irq();
    t_bond();
    test_done();
  end
endmodule : tb_top
